// ==== verilog/pcr_pkg.sv ====
// Purpose: Shared constants and types of the peripheral command register bank
// Assumes: APB slave, 32-bit data, one 250 MHz clock
// Notes:   Register index times four gives the byte address
// =====================================================================
package pcr_pkg;
    // =================================================================
    // Register map
    localparam logic [3:0] IDX_DIR      = 4'h0;
    localparam logic [3:0] IDX_CMD      = 4'h1;
    localparam logic [3:0] IDX_TRIG     = 4'hf;
    localparam int         ADDR_W       = 8;
    // =================================================================
    // Field layout and reset values
    localparam int         N_UNITS      = 3;
    localparam int         CMD_PRIO_LSB = 0;
    localparam int         CMD_PRIO_W   = 3;
    localparam int         CMD_RST_LSB  = 4;
    localparam int         TRIG_BIT     = 0;
    localparam logic [7:0] DIR_RESET    = 8'hff;
    localparam logic [2:0] PRIO_RESET   = 3'h0;
    // =================================================================
    // Timing
    localparam int         RECOV_CYCLES = 8;
    localparam logic [3:0] RECOV_LOAD   = 4'(RECOV_CYCLES - 2);
    // =================================================================
    // Chain orders: {third, second, first} unit index, two bits each
    localparam logic [5:0] PCR_ORDER [8] = '{6'h24, 6'h18, 6'h21, 6'h09,
                                             6'h12, 6'h06, 6'h24, 6'h24};
    typedef enum logic [1:0] {ST_IDLE, ST_RETURN, ST_RECOVER} pcr_state_t;
endpackage

// ==== verilog/pcr_if.sv ====
// Purpose: Carriers between the core and its register and chain helpers
// Assumes: One clock domain
// Notes:   Two interfaces, one per helper
`timescale 1ns/10ps
// =====================================================================
// Register access carrier
interface pcr_reg_if;
    logic       wr_stb;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       block;
    modport apb  (output wr_stb, idx, wdata, input rdata, block);
    modport core (input wr_stb, idx, wdata, output rdata, block);
endinterface
// =====================================================================
// Daisy chain carrier
interface pcr_chain_if;
    logic [2:0] order;
    logic       ret_go;
    logic       force_en;
    modport chain (input order, ret_go, force_en);
    modport core  (output order, ret_go, force_en);
endinterface

// ==== verilog/pcr_apb.sv ====
// Purpose: APB slave front end with zero wait states
// Assumes: Only byte lane 0 carries register data
// Notes:   Read data captured in the setup cycle
`timescale 1ns/10ps
module pcr_apb
    import pcr_pkg::*;
(
    input  wire logic              pclk,    // Clock
    input  wire logic              presetn, // Async reset, low
    input  wire logic [ADDR_W-1:0] paddr,   // Byte address
    input  wire logic              psel,    // Select
    input  wire logic              penable, // Access phase
    input  wire logic              pwrite,  // Write
    input  wire logic [31:0]       pwdata,  // Write data
    input  wire logic [3:0]        pstrb,   // Byte strobes
    output logic      [31:0]       prdata,  // Read data
    output logic                   pready,  // Ready
    output logic                   pslverr, // Unmapped address
    pcr_reg_if.apb                 rif      // To core
);
    typedef struct packed {
        logic [7:0] rd;
    } pcr_apb_st_t;
    pcr_apb_st_t s_q;
    pcr_apb_st_t s_d;
    logic        mapped;

    // =================================================================
    // Decode
    assign rif.idx   = paddr[5:2];
    assign rif.wdata = pwdata[7:0];
    assign mapped    = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                       (rif.idx == IDX_DIR || rif.idx == IDX_CMD ||
                        rif.idx == IDX_TRIG);
    assign rif.wr_stb = psel && penable && pwrite && pstrb[0] && mapped;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign prdata    = {24'h0000_00, s_q.rd};

    // Read data: blocked accesses drive zero
    always_comb begin
        s_d = s_q;
        if (psel && !penable && !pwrite) begin
            s_d.rd = (rif.block || !mapped) ? 8'h00 : rif.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ==== verilog/pcr_chain.sv ====
// Purpose: Daisy chain order and return targeting
// Assumes: Sub-units report their in-service state
// Notes:   Return pulse is registered
`timescale 1ns/10ps
module pcr_chain
    import pcr_pkg::*;
(
    input  wire logic               pclk,       // Clock
    input  wire logic               presetn,    // Async reset, low
    input  wire logic               chain_enable_in, // Chain enable in
    input  wire logic [N_UNITS-1:0] in_service, // Unit in service
    output logic      [N_UNITS-1:0] unit_en,    // Per-unit chain enable
    output logic                    chain_enable_out, // Chain enable out
    output logic      [N_UNITS-1:0] unit_return, // Return pulse per unit
    pcr_chain_if.chain              cif         // From core
);
    typedef struct packed {
        logic [N_UNITS-1:0] ret;
    } pcr_chain_st_t;
    pcr_chain_st_t s_q;
    pcr_chain_st_t s_d;
    logic [5:0]    ord;
    logic          en_eff;

    // Enable input is overridden during a software return
    assign ord    = PCR_ORDER[cif.order];
    assign en_eff = cif.force_en ? 1'b1 : chain_enable_in;
    assign chain_enable_out = en_eff && (in_service == '0);
    assign unit_return = s_q.ret;

    // Walk positions from highest priority down
    always_comb begin
        logic          blk;
        logic          hit;
        logic [1:0]    u;
        blk     = 1'b0;
        hit     = 1'b0;
        u       = 2'h0;
        unit_en = '0;
        s_d.ret = '0;
        for (int p = 0; p < N_UNITS; p++) begin
            u = ord[2*p +: 2];
            unit_en[u] = en_eff && !blk;
            if (in_service[u]) begin
                blk = 1'b1;
                if (cif.ret_go && !hit) begin
                    s_d.ret[u] = 1'b1;
                end
                hit = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ==== verilog/pcr_top.sv ====
// Purpose: Global command registers of a multi-function peripheral
// Assumes: Sub-units sit outside and take pulses and levels from here
// Notes:   Recovery lockout blocks all register accesses
`timescale 1ns/10ps
module pcr_top
    import pcr_pkg::*;
(
    input  wire logic               pclk,            // Clock
    input  wire logic               presetn,         // Async reset, low
    input  wire logic [ADDR_W-1:0]  paddr,           // APB address
    input  wire logic               psel,            // APB select
    input  wire logic               penable,         // APB enable
    input  wire logic               pwrite,          // APB write
    input  wire logic [31:0]        pwdata,          // APB write data
    input  wire logic [3:0]         pstrb,           // APB strobes
    output logic      [31:0]        prdata,          // APB read data
    output logic                    pready,          // APB ready
    output logic                    pslverr,         // APB error
    output logic      [7:0]         aux_port_oe,     // Line driven when high
    output logic      [N_UNITS-1:0] unit_reset,      // Reset pulse per unit
    output logic      [2:0]         chain_order,     // Priority order code
    input  wire logic               chain_enable_in, // Chain enable in
    input  wire logic [N_UNITS-1:0] unit_in_service, // Unit in service
    output logic      [N_UNITS-1:0] unit_chain_en,   // Per-unit enable
    output logic                    chain_enable_out, // Chain enable out
    output logic      [N_UNITS-1:0] unit_return      // Return pulse per unit
);
    typedef struct packed {
        logic [7:0]         dir;
        logic [2:0]         prio;
        logic [N_UNITS-1:0] rst;
        pcr_state_t         st;
        logic [3:0]         cnt;
    } pcr_top_st_t;
    pcr_top_st_t s_q;
    pcr_top_st_t s_d;
    logic        wr_ok;

    pcr_reg_if   rif ();
    pcr_chain_if cif ();

    // =================================================================
    // Bus front end
    pcr_apb u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rif     (rif)
    );

    // =================================================================
    // Daisy chain
    pcr_chain u_chain (
        .pclk             (pclk),
        .presetn          (presetn),
        .chain_enable_in  (chain_enable_in),
        .in_service       (unit_in_service),
        .unit_en          (unit_chain_en),
        .chain_enable_out (chain_enable_out),
        .unit_return      (unit_return),
        .cif              (cif)
    );

    // =================================================================
    // Outputs
    assign rif.block    = (s_q.st != ST_IDLE);
    assign wr_ok        = rif.wr_stb && !rif.block;
    assign cif.order    = s_q.prio;
    assign cif.ret_go   = (s_q.st == ST_RETURN);
    assign cif.force_en = rif.block;
    assign unit_reset   = s_q.rst;
    assign chain_order  = s_q.prio;

    // Direction bit one means input, so the driver is off
    for (genvar i = 0; i < 8; i++) begin : g_dir
        assign aux_port_oe[i] = !s_q.dir[i];
    end

    // Read mux; reset bits and trigger register read zero
    always_comb begin
        case (rif.idx)
            IDX_DIR: rif.rdata = s_q.dir;
            IDX_CMD: rif.rdata = {5'h00, s_q.prio};
            default: rif.rdata = 8'h00;
        endcase
    end

    // =================================================================
    // Register and sequencer next state
    always_comb begin
        s_d     = s_q;
        s_d.rst = '0;
        if (wr_ok && rif.idx == IDX_DIR) begin
            s_d.dir = rif.wdata;
        end
        if (wr_ok && rif.idx == IDX_CMD) begin
            s_d.prio = rif.wdata[CMD_PRIO_LSB +: CMD_PRIO_W];
            s_d.rst  = rif.wdata[CMD_RST_LSB +: N_UNITS];
        end
        case (s_q.st)
            ST_IDLE: begin
                if (wr_ok && rif.idx == IDX_TRIG && rif.wdata[TRIG_BIT]) begin
                    s_d.st = ST_RETURN;
                end
            end
            ST_RETURN: begin
                s_d.st  = ST_RECOVER;
                s_d.cnt = RECOV_LOAD;
            end
            ST_RECOVER: begin
                if (s_q.cnt == 4'h0) begin
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.dir  <= DIR_RESET;
            s_q.prio <= PRIO_RESET;
            s_q.rst  <= '0;
            s_q.st   <= ST_IDLE;
            s_q.cnt  <= 4'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // =================================================================
    // Checks
    sequence trig_go_s;
        rif.wr_stb && rif.idx == IDX_TRIG && rif.wdata[TRIG_BIT] && !rif.block;
    endsequence

    sequence cmd_wr_s;
        rif.wr_stb && rif.idx == IDX_CMD && !rif.block;
    endsequence

    property lockout_p;
        trig_go_s |=> rif.block [*8] ##1 !rif.block;
    endproperty

    dir_reset_a: assert property (@(posedge pclk)
        $rose(presetn) |-> aux_port_oe == 8'h00)
        else $error("direction not all inputs after reset");

    dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_stb && rif.idx == IDX_DIR && !rif.block
        |=> aux_port_oe == ~$past(pwdata[7:0]))
        else $error("direction write not applied");

    rst_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr_s |=> unit_reset == $past(pwdata[6:4]) ##1 unit_reset == '0)
        else $error("reset pulse not single cycle");

    prio_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr_s |=> chain_order == $past(pwdata[2:0]))
        else $error("priority order not updated");

    lockout_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        lockout_p)
        else $error("return lockout length wrong");

    zero_noeff_a: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_stb && rif.idx == IDX_TRIG && !rif.wdata[TRIG_BIT] && !rif.block
        |=> !rif.block && unit_return == '0)
        else $error("trigger zero had an effect");

    blocked_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        rif.block && rif.wr_stb |=> $stable(aux_port_oe) && $stable(chain_order))
        else $error("write taken during recovery");

    forced_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        rif.block && unit_in_service == '0 |-> chain_enable_out)
        else $error("chain enable not forced high");

    ret_target_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig_go_s ##1 unit_in_service != '0 |=> $onehot(unit_return)
        ##1 unit_return == '0)
        else $error("return pulse not single unit");
endmodule

// ==== tb/pcr_host.sv ====
// Purpose: Host model speaking APB to the command register bank
// Assumes: One clock, zero or more wait states from the slave
// Notes:   Tasks are called from the testbench top
`timescale 1ns/10ps
module pcr_host (
    input  wire logic        pclk,    // Clock
    output logic      [7:0]  paddr,   // Byte address
    output logic             psel,    // Select
    output logic             penable, // Access phase
    output logic             pwrite,  // Write
    output logic      [31:0] pwdata,  // Write data
    output logic      [3:0]  pstrb,   // Lane strobes
    input  wire logic [31:0] prdata,  // Read data
    input  wire logic        pready,  // Ready
    input  wire logic        pslverr  // Error
);
    // ================================================================
    // Idle bus at time zero
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
        pstrb = 4'h1;
    end
    // One transfer: setup, then access until ready; held until then
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait for ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ==== tb/peripheral_command_regs_tb_top.sv ====
// Purpose: Self-checking bench of the command register bank
// Assumes: Host model drives APB, bench drives the unit status lines
// Notes:   Sub-units drop their in-service flag on a return pulse
`timescale 1ns/10ps
module peripheral_command_regs_tb_top;
    import pcr_pkg::*;
    logic        pclk, presetn, pready, pslverr, psel, penable, pwrite;
    logic [7:0]  paddr, aux_port_oe;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  pstrb;
    logic [2:0]  unit_reset, chain_order, unit_in_service, unit_chain_en, unit_return;
    logic [2:0]  rst_seen, ret_seen;
    logic        chain_enable_in, chain_enable_out, err;
    int          n_errors, checks, rst_cyc, ret_cyc;

    pcr_host i_pcr_host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    pcr_top i_pcr_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_port_oe(aux_port_oe),
        .unit_reset(unit_reset), .chain_order(chain_order),
        .chain_enable_in(chain_enable_in), .unit_in_service(unit_in_service),
        .unit_chain_en(unit_chain_en), .chain_enable_out(chain_enable_out),
        .unit_return(unit_return));
    // ================================================================
    // Clock, and pulse monitors standing in for the sub-units
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (unit_reset !== 3'h0) begin
            rst_cyc++;
            rst_seen |= unit_reset;
        end
        if (unit_return !== 3'h0) begin
            ret_cyc++;
            ret_seen |= unit_return;
            unit_in_service <= unit_in_service & ~unit_return;
        end
    end
    // ================================================================
    // Compare, access and closing tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_pcr_host.xfer(1'b1, a, d, rdv, err);
    endtask
    task automatic rd(input logic [7:0] a);
        i_pcr_host.xfer(1'b0, a, 32'h0000_0000, rdv, err);
    endtask
    task automatic summarize;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Software return with given order and in-service set
    task automatic trig(input logic [2:0] ord, input logic [2:0] insvc,
                        input logic [2:0] exp);
        wr(8'h04, {29'h0, ord});
        unit_in_service <= insvc;
        chain_enable_in <= 1'b1;
        ret_cyc = 0;
        ret_seen = 3'h0;
        wr(8'h3C, 32'h0000_0001);
        chain_enable_in <= 1'b0;
        repeat (3) @(negedge pclk);
        check(chain_enable_out, (insvc & ~exp) == 3'h0);
        wr(8'h00, 32'h0000_0000);
        rd(8'h00);
        check(rdv, 32'h0000_0000);
        repeat (8) @(posedge pclk);
        rd(8'h00);
        check(rdv, 32'h0000_00a5);
        @(negedge pclk);
        check(chain_enable_out, 1'b0);
        check(ret_cyc, 1);
        check(ret_seen, exp);
    endtask
    // ================================================================
    // Main sequence
    initial begin
        n_errors = 0;
        checks = 0;
        rst_cyc = 0;
        rst_seen = 3'h0;
        presetn = 1'b0;
        chain_enable_in = 1'b1;
        unit_in_service = 3'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00);
        check(rdv, {24'h0, DIR_RESET});
        check(aux_port_oe, 8'h00);
        for (int c = 0; c < 6; c++) begin
            wr(8'h04, c);
            @(negedge pclk);
            check(chain_order, c);
            rd(8'h04);
            check(rdv, c);
        end
        wr(8'h00, 32'h0000_00a5);
        @(negedge pclk);
        check(aux_port_oe, 8'h5a);
        wr(8'h04, 32'h0000_0052);
        repeat (3) @(posedge pclk);
        check(rst_cyc, 1);
        check(rst_seen, 3'h5);
        rd(8'h04);
        check(rdv, 32'h0000_0002);
        rd(8'h08);
        check(err, 1'b1);
        ret_cyc = 0;
        unit_in_service <= 3'h1;
        wr(8'h3C, 32'h0000_0000);
        wr(8'h00, 32'h0000_00a5);
        rd(8'h00);
        check(rdv, 32'h0000_00a5);
        check(ret_cyc, 0);
        check(unit_chain_en, 3'h3);
        check(chain_enable_out, 1'b0);
        rd(8'h3C);
        trig(3'h0, 3'h6, 3'h2);
        trig(3'h5, 3'h4, 3'h4);
        summarize();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        summarize();
    end
endmodule
